// File: rtl/sdt_supervisory_timer_defines.vh
// constants of the supervisory timer: register map, fields, resets, timing
`ifndef SDT_SUPERVISORY_TIMER_DEFINES_VH
`define SDT_SUPERVISORY_TIMER_DEFINES_VH

// register indices; byte address is four times the index
`define SDT_IDX_ARM       8'hC8
`define SDT_IDX_CTRL2     8'hCC
`define SDT_IDX_COUNT     8'hCE
`define SDT_IDX_IRQ_STAT  8'hD0
`define SDT_IDX_IRQ_CLR   8'hD1
`define SDT_IDX_IRQ_EN    8'hD2

// field positions
`define SDT_ARM_BIT       0
`define SDT_UDF_BIT       0
`define SDT_IRQ_UDF_BIT   0
`define SDT_IRQ_START_BIT 1

// reset and load values
`define SDT_PRE_LOAD      8'hFF
`define SDT_CNT_LOAD      8'hFF
`define SDT_CNT_RST       8'hFF

// instruction cycle is the oscillator (mclk) divided by ten
`define SDT_TICK_DIV      4'hA
// oscillator start-up delay, in instruction cycles: one prescaler wrap
`define SDT_STARTUP_TICKS 9'h100

// axi responses
`define SDT_RESP_OKAY     2'h0
`define SDT_RESP_SLVERR   2'h2

`endif

// File: rtl/sdt_supervisory_timer.v
// supervisory timer: prescaled 8-bit down counter, reset arm, axi4-lite
//
// Contract
// - 8-bit rw counter paced by 8-bit prescaler
// - prescaler clocked by oscillator divided by ten
// - reset on underflow disabled after power-up
// - reset arm is bit 0 of arm register
// - arm writable once per external reset
// - counter at index 0CE, software loads n-1
// - counter write presets prescaler FF, starts both
// - armed underflow resets device, arm stays set
// - underflow stops prescaler and counter until reload
// - unarmed underflow sets flag, no device reset
// - hidden run flag, set by load, cleared by resets
// - read-only underflow flag, cleared load/halt/reset
// - halt entry loads FF, keeps arm and run
// - supervisory reset presets FF, clears run flag only
// - crystal wakeup reuses prescaler/counter as delay
// - crystal wakeup: oscillator only, clocks after 256
`include "sdt_supervisory_timer_defines.vh"

module sdt_supervisory_timer
(
   input  wire        mclk,
   input  wire        sys_rst,
   input  wire        clk_en,
   input  wire        halt_entry,
   input  wire        wakeup,
   input  wire        xtal_option,
   input  wire        brownout_rst,
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output reg         dog_reset_out,
   output reg         osc_enable,
   output reg         clocks_enable,
   output reg         irq
);

   localparam [1:0] MODE_RUN   = 2'h0;
   localparam [1:0] MODE_HALT  = 2'h1;
   localparam [1:0] MODE_START = 2'h2;

   // synchronisers for pin inputs
   reg  [1:0]  xtal_sync;
   reg  [1:0]  bor_sync;

   // timer state
   reg  [3:0]  div_cnt;
   reg  [7:0]  prescale;
   reg  [7:0]  dog_count_reg;
   reg         dog_reset_arm;
   reg         arm_locked;
   reg         dog_underflow_flag;
   reg         dog_run_flag;
   reg         counting;
   reg  [1:0]  mode;
   reg  [1:0]  irq_stat;
   reg  [1:0]  irq_en;

   // captured bus requests
   reg  [11:0] aw_addr;
   reg  [31:0] w_data;
   reg  [3:0]  w_strb;

   reg  [1:0]  next_mode;
   reg  [1:0]  next_irq_stat;
   reg  [31:0] next_rdata;
   reg         next_rerr;

   wire        xtal_opt  = xtal_sync[1];
   wire        bor       = bor_sync[1];

   wire        instr_cycle_clk;
   wire        pre_active;
   wire        pre_wrap;
   wire        cnt_step;
   wire        underflow;
   wire        wd_rst;
   wire        startup_done;
   wire        halt_go;

   wire        wr_fire;
   wire        wr_map;
   wire        wr_lane;
   wire [7:0]  wr_idx;
   wire [7:0]  rd_idx;
   wire        cnt_wr;
   wire        arm_wr;
   wire        clr_wr;
   wire        en_wr;
   wire        rd_take;

   // instruction cycle tick: oscillator divided by ten
   assign instr_cycle_clk = (div_cnt == (`SDT_TICK_DIV - 4'h1));

   // prescaler runs while the timer counts or during start-up
   assign pre_active = (mode == MODE_START) |
                       ((mode == MODE_RUN) & counting & dog_run_flag);
   assign pre_wrap   = pre_active & instr_cycle_clk &
                       (prescale == 8'h00);
   // one counter step per full prescaler count
   assign cnt_step   = pre_wrap & (mode == MODE_RUN);
   assign underflow  = cnt_step & (dog_count_reg == 8'h00);
   assign wd_rst     = underflow & dog_reset_arm;
   // 256 instruction cycles: one full prescaler pass from FF
   assign startup_done = pre_wrap & (mode == MODE_START);
   assign halt_go    = halt_entry & (mode == MODE_RUN);

   // write decode
   assign wr_fire = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
   assign wr_idx  = aw_addr[9:2];
   assign wr_map  = (aw_addr[11:10] == 2'h0) & (aw_addr[1:0] == 2'h0) &
                    ((wr_idx == `SDT_IDX_ARM) |
                     (wr_idx == `SDT_IDX_CTRL2) |
                     (wr_idx == `SDT_IDX_COUNT) |
                     (wr_idx == `SDT_IDX_IRQ_STAT) |
                     (wr_idx == `SDT_IDX_IRQ_CLR) |
                     (wr_idx == `SDT_IDX_IRQ_EN));
   assign wr_lane = wr_fire & wr_map & w_strb[0];
   assign cnt_wr  = wr_lane & (wr_idx == `SDT_IDX_COUNT);
   // arm register takes the first write only
   assign arm_wr  = wr_lane & (wr_idx == `SDT_IDX_ARM) & ~arm_locked;
   assign clr_wr  = wr_lane & (wr_idx == `SDT_IDX_IRQ_CLR);
   assign en_wr   = wr_lane & (wr_idx == `SDT_IDX_IRQ_EN);

   assign rd_idx  = s_axi_araddr[9:2];
   assign rd_take = s_axi_arvalid & s_axi_arready;

   // mode sequencing around halt and wakeup
   always @*
   begin
      next_mode = mode;
      case (mode)
         MODE_RUN:
            if (halt_entry)
               next_mode = MODE_HALT;
         MODE_HALT:
            // crystal: only the oscillator runs until the delay ends
            if (wakeup)
               next_mode = xtal_opt ? MODE_START : MODE_RUN;
         MODE_START:
            if (startup_done)
               next_mode = MODE_RUN;
         default:
            next_mode = MODE_RUN;
      endcase
   end

   // sticky interrupt status; a new event wins over a clear
   always @*
   begin
      next_irq_stat = irq_stat;
      if (clr_wr)
         next_irq_stat = irq_stat & ~w_data[1:0];
      if (underflow)
         next_irq_stat[`SDT_IRQ_UDF_BIT] = 1'b1;
      if (startup_done)
         next_irq_stat[`SDT_IRQ_START_BIT] = 1'b1;
   end

   // read mux; unmapped addresses answer slverr with zero data
   always @*
   begin
      next_rdata = 32'h00000000;
      next_rerr  = 1'b0;
      if ((s_axi_araddr[11:10] != 2'h0) || (s_axi_araddr[1:0] != 2'h0))
         next_rerr = 1'b1;
      else
      begin
         case (rd_idx)
            `SDT_IDX_ARM:
               next_rdata[`SDT_ARM_BIT] = dog_reset_arm;
            `SDT_IDX_CTRL2:
               next_rdata[`SDT_UDF_BIT] = dog_underflow_flag;
            `SDT_IDX_COUNT:
               next_rdata[7:0] = dog_count_reg;
            `SDT_IDX_IRQ_STAT:
               next_rdata[1:0] = irq_stat;
            `SDT_IDX_IRQ_CLR:
               next_rdata = 32'h00000000;
            `SDT_IDX_IRQ_EN:
               next_rdata[1:0] = irq_en;
            default:
               next_rerr = 1'b1;
         endcase
      end
   end

   // pin synchronisers
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         xtal_sync <= 2'h0;
         bor_sync  <= 2'h0;
      end
      else if (clk_en)
      begin
         xtal_sync <= {xtal_sync[0], xtal_option};
         bor_sync  <= {bor_sync[0], brownout_rst};
      end
   end

   // instruction cycle divider, stopped while halted
   always @(posedge mclk)
   begin
      if (sys_rst)
         div_cnt <= 4'h0;
      else if (clk_en)
      begin
         if (next_mode == MODE_HALT)
            div_cnt <= 4'h0;
         else if (instr_cycle_clk)
            div_cnt <= 4'h0;
         else
            div_cnt <= div_cnt + 4'h1;
      end
   end

   // prescaler and counter
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         prescale      <= `SDT_PRE_LOAD;
         dog_count_reg <= `SDT_CNT_RST;
      end
      else if (clk_en)
      begin
         if (cnt_wr)
         begin
            dog_count_reg <= w_data[7:0];
            prescale      <= `SDT_PRE_LOAD;
         end
         else if (halt_go)
         begin
            prescale      <= `SDT_PRE_LOAD;
            dog_count_reg <= `SDT_CNT_LOAD;
         end
         else if (wd_rst)
         begin
            prescale      <= `SDT_PRE_LOAD;
            dog_count_reg <= `SDT_CNT_LOAD;
         end
         else if (pre_active & instr_cycle_clk)
         begin
            // 00 wraps to FF, starting the next full count
            prescale <= prescale - 8'h01;
            // start-up pass alters the counter as well
            if (pre_wrap)
               dog_count_reg <= dog_count_reg - 8'h01;
         end
      end
   end

   // run control, underflow flag and reset arm
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         counting           <= 1'b0;
         dog_run_flag       <= 1'b0;
         dog_underflow_flag <= 1'b0;
         dog_reset_arm      <= 1'b0;
         arm_locked         <= 1'b0;
      end
      else if (clk_en)
      begin
         // any underflow stops the timer until the next load
         if (cnt_wr)
            counting <= 1'b1;
         else if (underflow)
            counting <= 1'b0;

         if (cnt_wr)
            dog_run_flag <= 1'b1;
         if (bor | wd_rst)
            dog_run_flag <= 1'b0;

         // set wins over load and halt clears
         dog_underflow_flag <= underflow |
            (dog_underflow_flag & ~(cnt_wr | halt_go));

         // arm survives supervisory reset and halt
         if (arm_wr)
         begin
            dog_reset_arm <= w_data[`SDT_ARM_BIT];
            arm_locked    <= 1'b1;
         end
      end
   end

   // mode, outputs and interrupt
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         mode          <= MODE_RUN;
         osc_enable    <= 1'b1;
         clocks_enable <= 1'b1;
         dog_reset_out <= 1'b0;
         irq_stat      <= 2'h0;
         irq_en        <= 2'h0;
         irq           <= 1'b0;
      end
      else if (clk_en)
      begin
         mode          <= next_mode;
         osc_enable    <= (next_mode != MODE_HALT);
         clocks_enable <= (next_mode == MODE_RUN);
         dog_reset_out <= wd_rst;
         irq_stat      <= next_irq_stat;
         if (en_wr)
            irq_en <= w_data[1:0];
         irq           <= |(irq_stat & irq_en);
      end
   end

   // axi4-lite write channel: address and data taken in either order
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `SDT_RESP_OKAY;
         aw_addr       <= 12'h000;
         w_data        <= 32'h00000000;
         w_strb        <= 4'h0;
      end
      else if (clk_en)
      begin
         if (s_axi_awvalid & s_axi_awready)
         begin
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready)
         begin
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? `SDT_RESP_OKAY : `SDT_RESP_SLVERR;
         end
         else if (s_axi_bvalid & s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // axi4-lite read channel
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `SDT_RESP_OKAY;
      end
      else if (clk_en)
      begin
         if (rd_take)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rerr ? `SDT_RESP_SLVERR
                                       : `SDT_RESP_OKAY;
         end
         else if (s_axi_rvalid & s_axi_rready)
         begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule // sdt_supervisory_timer

// File: tb/sdt_chk.sv
// protocol and timing assertions on the supervisory timer ports
module sdt_chk
(
   input wire        mclk,
   input wire        sys_rst,
   input wire        clk_en,
   input wire        halt_entry,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire        dog_reset_out,
   input wire        osc_enable,
   input wire        clocks_enable,
   input wire        irq
);
   timeunit 1ns;
   timeprecision 1ns;
   int unsigned sc;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   // cycles spent with the oscillator up but clocks still gated
   always @(posedge mclk)
      if (sys_rst || clocks_enable)
         sc <= 0;
      else if (osc_enable)
         sc <= sc + 1;
   chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
   chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
   chk_read_latency: assert property (clk_en && s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
   chk_aw_taken: assert property (clk_en && s_axi_awvalid && s_axi_awready
      |=> !s_axi_awready) else $error("awready stayed high");
   chk_dog_pulse: assert property (dog_reset_out && clk_en
      |=> !dog_reset_out) else $error("device reset pulse too long");
   chk_reset_exit: assert property ($fell(sys_rst) |-> !irq
      && !dog_reset_out && osc_enable && clocks_enable)
      else $error("outputs wrong after reset");
   chk_clock_gate: assert property (!osc_enable |-> !clocks_enable)
      else $error("clocks without oscillator");
   chk_halt_stop: assert property (halt_entry && clk_en
      && clocks_enable |-> ##[1:2] !osc_enable)
      else $error("halt not entered");
   chk_startup_len: assert property ($rose(clocks_enable) && sc != 0
      |-> sc > 2500 && sc < 2620) else $error("start-up delay wrong");
   chk_startup_cap: assert property (sc < 2700)
      else $error("start-up never ends");
endmodule // sdt_chk

bind sdt_supervisory_timer sdt_chk u_chk (.mclk, .sys_rst, .clk_en,
   .halt_entry, .s_axi_awvalid, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .dog_reset_out, .osc_enable,
   .clocks_enable, .irq);

// File: tb/tb.sv
// self-checking bench of the supervisory timer over axi4-lite
`include "sdt_supervisory_timer_defines.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk = 0, sys_rst = 1, clk_en = 1, halt_entry = 0;
   logic        wakeup = 0, xtal_option = 1, brownout_rst = 0;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0;
   logic [3:0]  s_axi_wstrb = 0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire         s_axi_rvalid, dog_reset_out, osc_enable, clocks_enable, irq;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   int          mismatches = 0, n_tests = 0, dogs = 0, t;
   logic [31:0] rd, c1;
   logic [1:0]  rs;

   sdt_supervisory_timer DUT (.mclk, .sys_rst, .clk_en, .halt_entry,
      .wakeup, .xtal_option, .brownout_rst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dog_reset_out,
      .osc_enable, .clocks_enable, .irq);

   initial
      forever #20 mclk = ~mclk;

   always @(posedge mclk)
      if (dog_reset_out === 1'b1)
         dogs <= dogs + 1;

   task automatic chk(input string nm, input logic [31:0] e, g);
      n_tests++;
      if (g !== e)
      begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         mismatches++;
      end
   endtask

   task automatic wr(input logic [7:0] i, input logic [31:0] d);
      @(posedge mclk);
      s_axi_awaddr <= {2'b00, i, 2'b00};
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do
      begin
         @(posedge mclk);
         if (s_axi_awready)
            s_axi_awvalid <= 0;
         if (s_axi_wready)
            s_axi_wvalid <= 0;
      end
      while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 0;
      chk("bresp", `SDT_RESP_OKAY, s_axi_bresp);
   endtask

   task automatic rdr(input logic [7:0] i, output logic [31:0] d,
                      output logic [1:0] r);
      @(posedge mclk);
      s_axi_araddr <= {2'b00, i, 2'b00};
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do
      begin
         @(posedge mclk);
         if (s_axi_arready)
            s_axi_arvalid <= 0;
      end
      while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 0;
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask

   task automatic rc(input string nm, input logic [7:0] i,
                     input logic [31:0] e);
      rdr(i, rd, rs);
      chk(nm, e, rd);
      chk("rresp", `SDT_RESP_OKAY, rs);
   endtask

   task automatic pulse_halt;
      @(posedge mclk);
      halt_entry <= 1;
      @(posedge mclk);
      halt_entry <= 0;
   endtask

   task end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial
   begin
      #(40 * 40000);
      mismatches++;
      end_of_test();
   end

   initial
   begin
      repeat (16) @(posedge mclk);
      sys_rst <= 0;
      rc("count at reset", `SDT_IDX_COUNT, `SDT_CNT_RST);
      rc("arm at reset", `SDT_IDX_ARM, 0);
      rc("flag at reset", `SDT_IDX_CTRL2, 0);
      rdr(8'h10, rd, rs);
      chk("unmapped resp", `SDT_RESP_SLVERR, rs);
      chk("unmapped data", 0, rd);
      $display("test reset done");
      // interval timer: n-1 = 1 gives two steps of 256 ticks
      wr(`SDT_IDX_IRQ_EN, 32'h3);
      wr(`SDT_IDX_COUNT, 32'h1);
      t = 0;
      while (irq !== 1'b1 && t < 6000)
      begin
         @(posedge mclk);
         t++;
      end
      chk("underflow time", 1, t > 5090 && t < 5140);
      rc("flag set", `SDT_IDX_CTRL2, 1);
      chk("no device reset", 0, dogs);
      rc("status", `SDT_IDX_IRQ_STAT, 1);
      rdr(`SDT_IDX_COUNT, c1, rs);
      repeat (2600) @(posedge mclk);
      rc("count stopped", `SDT_IDX_COUNT, c1);
      wr(`SDT_IDX_IRQ_CLR, 32'h1);
      rc("status cleared", `SDT_IDX_IRQ_STAT, 0);
      chk("irq low", 0, irq);
      $display("test timer done");
      // halt entry then crystal wakeup through the start-up delay
      pulse_halt();
      rc("count halt", `SDT_IDX_COUNT, `SDT_CNT_LOAD);
      rc("flag halt", `SDT_IDX_CTRL2, 0);
      chk("osc in halt", 0, osc_enable);
      @(posedge mclk);
      wakeup <= 1;
      @(posedge mclk);
      wakeup <= 0;
      @(posedge mclk);
      chk("osc on wakeup", 1, osc_enable);
      chk("clocks gated", 0, clocks_enable);
      t = 0;
      while (clocks_enable !== 1'b1 && t < 3000)
      begin
         @(posedge mclk);
         t++;
      end
      chk("start-up time", 1, t > 2500 && t < 2620);
      rc("start-up status", `SDT_IDX_IRQ_STAT, 2);
      rc("count after delay", `SDT_IDX_COUNT, 32'hFE);
      wr(`SDT_IDX_IRQ_CLR, 32'h3);
      $display("test halt done");
      // armed supervisor: one arm write only, reset on underflow
      wr(`SDT_IDX_ARM, 32'h1);
      wr(`SDT_IDX_ARM, 32'h0);
      rc("arm locked", `SDT_IDX_ARM, 1);
      wr(`SDT_IDX_COUNT, 32'h0);
      t = 0;
      while (dogs == 0 && t < 3000)
      begin
         @(posedge mclk);
         t++;
      end
      chk("device reset", 1, dogs);
      rc("count after reset", `SDT_IDX_COUNT, `SDT_CNT_LOAD);
      rc("arm kept", `SDT_IDX_ARM, 1);
      rc("flag kept", `SDT_IDX_CTRL2, 1);
      wr(`SDT_IDX_COUNT, 32'h5);
      rc("flag load", `SDT_IDX_CTRL2, 0);
      rc("count load", `SDT_IDX_COUNT, 32'h5);
      // armed: reloads spaced below one underflow period keep it quiet
      repeat (3)
      begin
         repeat (2000) @(posedge mclk);
         wr(`SDT_IDX_COUNT, 32'h0);
      end
      chk("serviced no reset", 1, dogs);
      brownout_rst <= 1;
      repeat (4) @(posedge mclk);
      brownout_rst <= 0;
      repeat (2800) @(posedge mclk);
      chk("brownout no reset", 1, dogs);
      rc("count brownout", `SDT_IDX_COUNT, 32'h0);
      sys_rst <= 1;
      repeat (3) @(posedge mclk);
      sys_rst <= 0;
      rc("arm ext reset", `SDT_IDX_ARM, 0);
      wr(`SDT_IDX_ARM, 32'h1);
      rc("arm rewritten", `SDT_IDX_ARM, 1);
      $display("test arm done");
      // no crystal: wakeup resumes clocks without start-up delay
      xtal_option <= 0;
      pulse_halt();
      @(posedge mclk);
      wakeup <= 1;
      @(posedge mclk);
      wakeup <= 0;
      @(posedge mclk);
      chk("rc wakeup osc", 1, osc_enable);
      chk("rc wakeup clocks", 1, clocks_enable);
      $display("test wakeup done");
      end_of_test();
   end
endmodule // tb
